// File: core/adc_area_decode.sv
// Area decoder and chip select output logic
// Notes on behaviour
// R1 - Control bits 7..4 enable area selects 7..4; cleared after initialisation.
// R2 - Enabled select owns its shared pin, overriding other pin functions. Only selects 7..4 do so here; pins 3..0 stay on their other function.
// R3 - Control register writes ignored in single-chip mode.
// R4 - Reset and hardware standby load 0x0F; software standby keeps contents.
// R5 - Control bits 3..0 read as one and ignore writes.
// R6 - Eight areas: 128 kbytes in 1-Mbyte modes, 2 Mbytes in 16-Mbyte modes.
// R7 - Width bit picks 16 or 8 bit bus; state bit picks 2 or 3 states.
// R8 - One distinct select per area, 7 down to 0.
// R9 - External space above area 7 uses area 7 settings.
// R10 - Wait enable and mode bits choose wait mode in three-state areas.
// R11 - Select is decoded from address, low while its area is accessed.
// R12 - On-chip ROM, RAM and register accesses keep all selects high.
// R13 - Area number from address bits 19..17 or 23..21.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module adc_area_decode
    import adc_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic hw_standby_in,
    input wire logic single_chip_in,
    input wire logic mode_16m_in,
    input wire logic [23:0] addr_in,
    input wire logic access_in,
    input wire logic on_chip_in,
    input wire logic [7:0] pin_alt_out_in,
    input wire logic [7:0] pin_alt_oe_n_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic [7:0] area_select_n_out,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n_out,
    output logic [7:0] area_select_out_en_n_out,
    output logic bus8_out,
    output logic [1:0] states_out,
    output logic [2:0] wait_mode_out
);
    logic [7:0] sel_ctrl_q, sel_ctrl_d;
    logic [7:0] width_q, width_d;
    logic [7:0] states_q, states_d;
    logic [7:0] wait_en_q, wait_en_d;
    logic [7:0] wait_ctrl_q, wait_ctrl_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] sel_n_q, sel_n_d;
    logic [2:0] area;
    logic external;
    logic beyond7;

    // Area number from the bits just above the per-area offset
    function automatic logic [2:0] area_of(input logic [23:0] a, input logic m16);
        area_of = m16 ? a[ADC_AREA_LSB_16M +: 3] : a[ADC_AREA_LSB_1M +: 3];
    endfunction

    // Address decode for the current access
    always_comb begin
        beyond7 = !mode_16m_in && (addr_in > ADC_TOP_1M);
        area = beyond7 ? 3'h7 : area_of(addr_in, mode_16m_in); // R6 R13 R9
        external = access_in && !on_chip_in; // R12
    end

    adc_area_spec u_spec (
        .area_in(area),
        .width_in(width_q),
        .states_in(states_q),
        .wait_en_in(wait_en_q),
        .wait_ctrl_in(wait_ctrl_q),
        .bus8_out(bus8_out),
        .states_out(states_out),
        .wait_mode_out(wait_mode_out)
    );

    // Register writes, reads and select decode
    always_comb begin
        sel_ctrl_d = sel_ctrl_q;
        width_d = width_q;
        states_d = states_q;
        wait_en_d = wait_en_q;
        wait_ctrl_d = wait_ctrl_q;
        rdata_d = rdata_q;
        if (reg_wr_in) begin
            if (reg_addr_in == ADC_REG_SEL_CTRL) begin
                if (!single_chip_in) begin // R3
                    sel_ctrl_d = reg_wdata_in | ADC_SEL_RO_MASK; // R5
                end
            end else if (reg_addr_in == ADC_REG_WIDTH) begin
                width_d = reg_wdata_in;
            end else if (reg_addr_in == ADC_REG_STATES) begin
                states_d = reg_wdata_in;
            end else if (reg_addr_in == ADC_REG_WAIT_EN) begin
                wait_en_d = reg_wdata_in;
            end else if (reg_addr_in == ADC_REG_WAIT_CTRL) begin
                wait_ctrl_d = reg_wdata_in;
            end
        end
        if (reg_rd_in) begin
            if (reg_addr_in == ADC_REG_SEL_CTRL) begin
                rdata_d = sel_ctrl_q | ADC_SEL_RO_MASK; // R5
            end else if (reg_addr_in == ADC_REG_WIDTH) begin
                rdata_d = width_q;
            end else if (reg_addr_in == ADC_REG_STATES) begin
                rdata_d = states_q;
            end else if (reg_addr_in == ADC_REG_WAIT_EN) begin
                rdata_d = wait_en_q;
            end else if (reg_addr_in == ADC_REG_WAIT_CTRL) begin
                rdata_d = wait_ctrl_q;
            end else if (reg_addr_in == ADC_REG_STATUS) begin
                rdata_d = {~sel_n_q[7:3], area};
            end else begin
                rdata_d = 8'h00;
            end
        end
        sel_n_d = 8'hFF;
        if (external) begin
            sel_n_d[area] = 1'b0; // R8 R11
        end
    end

    // Register state; hardware standby acts like reset, software standby not at all
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel_ctrl_q <= ADC_SEL_CTRL_RST; // R4
            width_q <= ADC_WIDTH_RST;
            states_q <= ADC_STATES_RST;
            wait_en_q <= ADC_WAIT_EN_RST;
            wait_ctrl_q <= ADC_WAIT_CTRL_RST;
            rdata_q <= 8'h00;
            sel_n_q <= 8'hFF;
        end else if (hw_standby_in) begin
            sel_ctrl_q <= ADC_SEL_CTRL_RST; // R4
            width_q <= ADC_WIDTH_RST;
            states_q <= ADC_STATES_RST;
            wait_en_q <= ADC_WAIT_EN_RST;
            wait_ctrl_q <= ADC_WAIT_CTRL_RST;
            rdata_q <= 8'h00;
            sel_n_q <= 8'hFF;
        end else begin
            sel_ctrl_q <= sel_ctrl_d;
            width_q <= width_d;
            states_q <= states_d;
            wait_en_q <= wait_en_d;
            wait_ctrl_q <= wait_ctrl_d;
            rdata_q <= rdata_d;
            sel_n_q <= sel_n_d;
        end
    end

    // Pin muxing: an enabled select 7..4 overrides the pin's other function; pins 3..0 always keep theirs
    always_comb begin
        area_select_out_en_n_out = {~sel_ctrl_q[7:4], 4'h0}; // R1
        for (int i = 0; i < 8; i++) begin
            if (!area_select_out_en_n_out[i] && i >= 4) begin
                pin_out[i] = sel_n_q[i]; // R2
                pin_oe_n_out[i] = 1'b0;
            end else begin
                pin_out[i] = pin_alt_out_in[i];
                pin_oe_n_out[i] = pin_alt_oe_n_in[i];
            end
        end
    end

    assign area_select_n_out = sel_n_q;
    assign reg_rdata_out = rdata_q;

    // Register checks: read-only bits, single-chip lock, standby reload, read port
    sel_ctrl_ro_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R5
        sel_ctrl_q[3:0] == 4'hF) else $error("low control bits not ones");
    single_chip_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R3
        single_chip_in && !hw_standby_in |=> $stable(sel_ctrl_q)) else $error("control changed in single-chip");
    hw_standby_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R4
        hw_standby_in |=> sel_ctrl_q == ADC_SEL_CTRL_RST) else $error("standby did not load 0x0F");
    hw_regs_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R4
        hw_standby_in |=> width_q == ADC_WIDTH_RST && states_q == ADC_STATES_RST
        && wait_en_q == ADC_WAIT_EN_RST && wait_ctrl_q == ADC_WAIT_CTRL_RST)
        else $error("standby did not reload registers");
    ctrl_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
        reg_wr_in && reg_addr_in == ADC_REG_SEL_CTRL && !single_chip_in && !hw_standby_in
        |=> sel_ctrl_q == ($past(reg_wdata_in) | ADC_SEL_RO_MASK)) else $error("control write lost");
    ctrl_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R5
        reg_rd_in && reg_addr_in == ADC_REG_SEL_CTRL && !hw_standby_in
        |=> reg_rdata_out[3:0] == 4'hF) else $error("control read low bits not ones");
    width_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
        reg_rd_in && reg_addr_in == ADC_REG_WIDTH && !hw_standby_in
        |=> reg_rdata_out == $past(width_q)) else $error("width read wrong");
    unmapped_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R5
        reg_rd_in && reg_addr_in > ADC_REG_STATUS && !hw_standby_in
        |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");

    // Select decode checks
    on_chip_high_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R12
        on_chip_in && !hw_standby_in |=> sel_n_q == 8'hFF) else $error("select low on on-chip access");
    select_low_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R8 R11
        access_in && !on_chip_in && !hw_standby_in |=> !sel_n_q[$past(area)] && $onehot(~sel_n_q))
        else $error("wrong area select");
    idle_high_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R11
        !access_in && !hw_standby_in |=> sel_n_q == 8'hFF) else $error("select low with no access");
    area_bits_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R13
        mode_16m_in |-> area == addr_in[23:21]) else $error("16M area bits wrong");
    area_bits_1m_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R6 R13
        !mode_16m_in && addr_in <= ADC_TOP_1M |-> area == addr_in[19:17]) else $error("1M area bits wrong");
    beyond_seven_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R9
        !mode_16m_in && addr_in > ADC_TOP_1M |-> area == 3'h7) else $error("beyond area 7");

    // Pin mux and bus specification checks
    pin_override_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R2
        sel_ctrl_q[5] |-> !pin_oe_n_out[5] && pin_out[5] == sel_n_q[5]) else $error("pin not overridden");
    pin_release_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
        !sel_ctrl_q[4] |-> pin_oe_n_out[4] == pin_alt_oe_n_in[4] && pin_out[4] == pin_alt_out_in[4])
        else $error("pin taken while select disabled");
    low_pins_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
        pin_oe_n_out[3:0] == pin_alt_oe_n_in[3:0] && pin_out[3:0] == pin_alt_out_in[3:0])
        else $error("low pins not on alternate function");
    bus_width_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
        bus8_out == width_q[area] && (states_out == ADC_STATES_SLOW) == states_q[area]) else $error("area spec wrong");
    wait_pin0_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R10
        states_q[area] && !wait_en_q[area] |-> wait_mode_out == ADC_WM_PIN0) else $error("pin wait 0 missing");
    wait_none_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R10
        !states_q[area] |-> wait_mode_out == ADC_WM_NONE) else $error("wait mode in two-state area");
endmodule
`default_nettype wire

// File: core/adc_area_spec.sv
// Per-area bus specification lookup
`timescale 1ns/1ps
`default_nettype none
module adc_area_spec
    import adc_pkg::*;
(
    input wire logic [2:0] area_in,
    input wire logic [7:0] width_in,
    input wire logic [7:0] states_in,
    input wire logic [7:0] wait_en_in,
    input wire logic [7:0] wait_ctrl_in,
    output logic bus8_out,
    output logic [1:0] states_out,
    output logic [2:0] wait_mode_out
);
    logic [1:0] wms;
    // Width, state count and wait mode for the selected area
    always_comb begin
        wms = {wait_ctrl_in[ADC_WMS_HI_POS], wait_ctrl_in[ADC_WMS_LO_POS]};
        bus8_out = width_in[area_in]; // R7
        states_out = states_in[area_in] ? ADC_STATES_SLOW : ADC_STATES_FAST; // R7
        if (!states_in[area_in]) begin
            wait_mode_out = ADC_WM_NONE;
        end else if (!wait_en_in[area_in]) begin
            wait_mode_out = ADC_WM_PIN0; // R10
        end else begin
            case (wms) // R10
                2'h0: wait_mode_out = ADC_WM_PROG;
                2'h1: wait_mode_out = ADC_WM_NONE;
                2'h2: wait_mode_out = ADC_WM_PIN1;
                default: wait_mode_out = ADC_WM_AUTO;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: dv/adc_area_decode_bench.sv
// Self-checking bench for the area decoder
`timescale 1ns/1ps
`default_nettype none
module adc_area_decode_bench;
    import adc_pkg::*;
    logic clock_in = 0, rst_n_in = 0, hw_standby_in = 0, single_chip_in = 0, mode_16m_in = 0;
    logic access_in = 0, on_chip_in = 0, reg_wr_in = 0, reg_rd_in = 0, bus8_out;
    logic [23:0] addr_in = 0;
    logic [2:0] reg_addr_in = 0, wait_mode_out;
    logic [7:0] pin_alt_out_in = 0, pin_alt_oe_n_in = 8'hFF, reg_wdata_in = 0, reg_rdata_out;
    logic [7:0] area_select_n_out, pin_out, pin_oe_n_out, area_select_out_en_n_out, wire_seen;
    logic [1:0] states_out;
    logic [7:0] d, ex, ctrl, wid, st, wen, wctl;
    int num_errors = 0, checks_done = 0, cycles = 0, seed = 32'h9dbbc878, a, e, f;
    adc_area_decode u_adc_area_decode (.clock_in, .rst_n_in, .hw_standby_in, .single_chip_in,
        .mode_16m_in, .addr_in, .access_in, .on_chip_in, .pin_alt_out_in, .pin_alt_oe_n_in,
        .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .area_select_n_out,
        .pin_out, .pin_oe_n_out, .area_select_out_en_n_out, .bus8_out, .states_out, .wait_mode_out);
    adc_ext_dev u_adc_ext_dev (.pin_in(pin_out), .pin_oe_n_in(pin_oe_n_out), .wire_out(wire_seen));
    // Clock and hang guard
    initial forever #10 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        checks_done++;
        if (g !== x) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic wr(input logic [2:0] ad, input logic [7:0] v);
        @(posedge clock_in);
        reg_addr_in <= ad;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] ad, output logic [7:0] v);
        @(posedge clock_in);
        reg_addr_in <= ad;
        reg_rd_in <= 1'b1;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        @(negedge clock_in);
        v = reg_rdata_out;
    endtask
    // Reference area number and wait mode
    function automatic int area_of(input logic [23:0] ad, input logic m16);
        if (m16) return int'(ad[23:21]);
        if (ad > ADC_TOP_1M) return 7;
        return int'(ad[19:17]);
    endfunction
    function automatic logic [2:0] wm(input int n);
        if (!st[n]) return ADC_WM_NONE;
        if (!wen[n]) return ADC_WM_PIN0;
        case (wctl[3:2])
            2'h0: return ADC_WM_PROG;
            2'h1: return ADC_WM_NONE;
            2'h2: return ADC_WM_PIN1;
            default: return ADC_WM_AUTO;
        endcase
    endfunction
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clock_in);
        rst_n_in <= 1'b1;
        rd(ADC_REG_SEL_CTRL, d); chk("ctrl", ADC_SEL_CTRL_RST, d);
        rd(3'h6, d); chk("unmapped", 8'h00, d);
        wr(ADC_REG_SEL_CTRL, 8'h50);
        rd(ADC_REG_SEL_CTRL, d); chk("ctrl", 8'h5F, d);
        chk("out_en_n", 8'hA0, area_select_out_en_n_out);
        @(posedge clock_in);
        single_chip_in <= 1'b1;
        wr(ADC_REG_SEL_CTRL, 8'hF0);
        rd(ADC_REG_SEL_CTRL, d); chk("ctrl", 8'h5F, d);
        @(posedge clock_in);
        single_chip_in <= 1'b0;
        for (int k = 0; k < 240; k++) begin
            if (k % 20 == 0) begin
                {ctrl, wid, st, wen} = {$random(seed)};
                wctl = 8'($random(seed));
                ctrl = ctrl | 8'h0F;
                wr(ADC_REG_SEL_CTRL, ctrl); wr(ADC_REG_WIDTH, wid); wr(ADC_REG_STATES, st);
                wr(ADC_REG_WAIT_EN, wen); wr(ADC_REG_WAIT_CTRL, wctl);
                rd(ADC_REG_WIDTH, d); chk("width", wid, d);
                rd(ADC_REG_WAIT_CTRL, d);
                chk("wait_ctrl", wctl, d);
            end
            @(posedge clock_in);
            e = $random(seed);
            f = $random(seed);
            addr_in <= e[23:0]; mode_16m_in <= f[0]; access_in <= f[1]; on_chip_in <= f[2];
            pin_alt_out_in <= f[15:8]; pin_alt_oe_n_in <= f[23:16];
            @(posedge clock_in);
            @(negedge clock_in);
            a = area_of(e[23:0], f[0]);
            ex = (f[1] && !f[2]) ? ~(8'h01 << a) : 8'hFF;
            chk("select", ex, area_select_n_out);
            chk("bus8", {7'h0, wid[a]}, {7'h0, bus8_out});
            chk("states", st[a] ? 8'h03 : 8'h02, {6'h0, states_out});
            chk("wait_mode", {5'h0, wm(a)}, {5'h0, wait_mode_out});
            for (int i = 0; i < 8; i++) begin
                d[i] = (i > 3 && ctrl[i]) ? ex[i] : (f[16 + i] ? 1'b1 : f[8 + i]);
            end
            chk("pins", d, wire_seen);
            // Status shows the live selects 7..3 and the area while the inputs hold still
            if (k % 20 == 19) begin
                rd(ADC_REG_STATUS, d);
                chk("status", {~ex[7:3], 3'(a)}, d);
            end
        end
        @(posedge clock_in);
        hw_standby_in <= 1'b1;
        @(posedge clock_in);
        hw_standby_in <= 1'b0;
        rd(ADC_REG_SEL_CTRL, d); chk("ctrl", ADC_SEL_CTRL_RST, d);
        rd(ADC_REG_WIDTH, d);
        chk("width", ADC_WIDTH_RST, d);
        wrap_up();
    end
endmodule
`default_nettype wire

// File: dv/adc_ext_dev.sv
// Model of the external devices watching the shared select pins
`timescale 1ns/1ps
`default_nettype none
module adc_ext_dev (
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_oe_n_in,
    output logic [7:0] wire_out
);
    // Undriven pins float high through board pull-ups
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            wire_out[i] = pin_oe_n_in[i] ? 1'b1 : pin_in[i];
        end
    end
endmodule
`default_nettype wire

// File: include/adc_pkg.sv
// Package: constants for the area decode and chip select block
package adc_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] ADC_REG_SEL_CTRL = 3'h0;
    localparam logic [2:0] ADC_REG_WIDTH = 3'h1;
    localparam logic [2:0] ADC_REG_STATES = 3'h2;
    localparam logic [2:0] ADC_REG_WAIT_EN = 3'h3;
    localparam logic [2:0] ADC_REG_WAIT_CTRL = 3'h4;
    localparam logic [2:0] ADC_REG_STATUS = 3'h5;
    // Reset values
    localparam logic [7:0] ADC_SEL_CTRL_RST = 8'h0F;
    localparam logic [7:0] ADC_WIDTH_RST = 8'hFF;
    localparam logic [7:0] ADC_STATES_RST = 8'hFF;
    localparam logic [7:0] ADC_WAIT_EN_RST = 8'hFF;
    localparam logic [7:0] ADC_WAIT_CTRL_RST = 8'h03;
    // Field positions
    localparam int ADC_WMS_LO_POS = 2;
    localparam int ADC_WMS_HI_POS = 3;
    localparam logic [7:0] ADC_SEL_RO_MASK = 8'h0F;
    // Address fields: area number sits above the per-area offset
    localparam int ADC_AREA_LSB_1M = 17;
    localparam int ADC_AREA_LSB_16M = 21;
    localparam logic [23:0] ADC_TOP_1M = 24'h0FFFFF;
    // Wait mode encodings
    localparam logic [2:0] ADC_WM_NONE = 3'h0;
    localparam logic [2:0] ADC_WM_PIN0 = 3'h1;
    localparam logic [2:0] ADC_WM_PROG = 3'h2;
    localparam logic [2:0] ADC_WM_PIN1 = 3'h3;
    localparam logic [2:0] ADC_WM_AUTO = 3'h4;
    // Access state counts
    localparam logic [1:0] ADC_STATES_FAST = 2'h2;
    localparam logic [1:0] ADC_STATES_SLOW = 2'h3;
endpackage
